// ### shared/crs_pkg.sv
// Shared types and constants for the core register set block.
// Assumes one clock domain; the instruction sequencer drives crs_cmd_t.
package crs_pkg;
  // ************************************************************
  // Reset values and fixed vectors
  // ************************************************************
  localparam logic [15:0] CRS_STACK_RESET = 16'h00ff;
  localparam logic [7:0] CRS_STACK_LOW_REINIT = 8'hff;
  localparam logic [15:0] CRS_RESET_VEC = 16'hfffe;
  localparam logic [15:0] CRS_BREAK_VEC = 16'hfffc;
  localparam logic [15:0] CRS_BREAK_VEC_MON = 16'hfefc;
  localparam logic [7:0] CRS_OPC_STACK_ADD = 8'ha7;
  localparam logic [7:0] CRS_OPC_POINTER_ADD = 8'haf;
  localparam logic [2:0] CRS_FRAME_LAST = 3'h4;
  localparam logic [2:0] CRS_CNT_RESET = 3'h0;
  // ************************************************************
  // Register window offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] CRS_OFS_INDEX = 8'h00;
  localparam logic [7:0] CRS_OFS_STACK = 8'h04;
  localparam logic [7:0] CRS_OFS_FETCH = 8'h08;
  localparam logic [7:0] CRS_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] CRS_OFS_CTRL = 8'h10;
  localparam logic [7:0] CRS_OFS_STAT = 8'h14;
  localparam int CRS_CTRL_BRK_EN = 0;
  localparam int CRS_CTRL_MON = 1;
  localparam logic [1:0] CRS_CTRL_RESET = 2'h0;

  typedef struct packed {
    logic v;
    logic one6;
    logic one5;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } crs_flags_t;
  localparam crs_flags_t CRS_FLAGS_RESET = 8'h68;

  typedef enum logic [4:0] {
    OP_BOUNDARY, OP_FETCH, OP_JUMP, OP_BRANCH, OP_LOAD_INDEX, OP_LOAD_STACK,
    OP_STACK_LOW_REINIT, OP_PUSH_BYTE, OP_PUSH_POINTER_HIGH, OP_PULL_ACC,
    OP_PULL_POINTER_HIGH, OP_UNMASK, OP_MASK, OP_SOFT_TRAP, OP_TRAP_RETURN,
    OP_IMM_ADD, OP_EA_X8, OP_EA_X16, OP_EA_STK8, OP_EA_STK16, OP_ADD, OP_ADC,
    OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR, OP_LDA, OP_ASL, OP_LSR, OP_ASR,
    OP_BIT_TEST
  } crs_kind_t;

  typedef struct packed {
    logic valid;
    crs_kind_t kind;
    logic [15:0] data;
  } crs_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crs_mem_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_STACK = 3'b001,
    S_VEC = 3'b011,
    S_DONE = 3'b010,
    S_UNSTACK = 3'b110,
    S_IMM = 3'b111
  } crs_state_t;

  typedef enum logic [2:0] {
    T_NONE, T_FETCH_HI, T_FETCH_LO, T_FLAGS, T_ACC, T_IDX_LO, T_IDX_HI
  } crs_tag_t;
endpackage : crs_pkg

// ### verilog/crs_core_regs.sv
// Programmer-visible register set with flags, stacking and vectoring.
// Assumes a same-clock sequencer on cmd, a memory that answers a read
// combinationally within the cycle mem.rd is high, and an APB master.
//
// Function
// RULE1: Sixteen-bit index pair from high and low bytes, for addressing and data.
// RULE2: Reset loads stack pointer with 00FF.
// RULE3: Stack low reinit sets low byte to FF, high byte kept.
// RULE4: Stack pointer names next free byte; push decrements, pull increments.
// RULE5: Stack-relative address is stack pointer plus 8- or 16-bit offset.
// RULE6: Fetch counter increments per fetch; jumps, branches, traps load it.
// RULE7: Leaving reset, fetch counter loads from vector FFFE high, FFFF low.
// RULE8: Flag bits 6 and 5 always read one.
// RULE9: Overflow flag marks signed overflow; signed branches use it.
// RULE10: Half-carry marks carry from bit 3 to 4 on add.
// RULE11: Mask bit set blocks maskable requests; clear accepts them.
// RULE12: Trap entry stacks registers, then sets mask, then fetches vector.
// RULE13: Trap entry never stacks index high byte; software saves it.
// RULE14: Trap return pulls registers and restores mask from stack.
// RULE15: Reset sets mask; the unmask op clears it. Trap return also clears it when the stacked flags byte has mask clear.
// RULE16: Negative flag equals result bit 7.
// RULE17: Zero flag set for zero result, else cleared.
// RULE18: Carry from bit 7 on add, borrow on subtract; shifts, bit tests too.
// RULE19: Break with function enabled traps via FFFC, or FEFC in monitor mode.
// RULE20: Trap return in break handler ends break once request is gone.
// RULE21: Highest-priority pending request is serviced first.
// RULE22: Stack add immediate, opcode A7, sign-extends, two cycles, flags kept.
// RULE23: Pointer add immediate, opcode AF, sign-extends into index, flags kept.
// RULE24: Flags not listed for an operation stay unchanged.
// RULE25: Core registers live in the core, outside the memory map.
`timescale 1ns/1ps
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter logic [15:0] IRQ_VEC_TOP = 16'hfffa
)(
  input wire logic clk, // 125 MHz core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire crs_pkg::crs_cmd_t cmd, // Operation from sequencer
  input wire logic [7:0] mem_rdata, // Memory read data
  input wire logic [NUM_IRQ-1:0] irq_pend, // Maskable requests, bit 0 highest
  input wire logic brk_req, // Break request from break logic
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output crs_pkg::crs_mem_t mem, // Memory request
  output logic busy, // Sequence in progress
  output logic [15:0] index_pair, // Index pair
  output logic [15:0] stack_top_pointer, // Stack pointer
  output logic [15:0] fetch_address_counter, // Fetch counter
  output crs_pkg::crs_flags_t result_flag_register, // Flags
  output logic [7:0] acc, // Accumulator
  output logic [15:0] eff_addr, // Operand address
  output logic irq_ack, // Maskable request taken
  output logic [7:0] irq_ack_idx, // Index of request taken
  output logic brk_active, // Break handling in progress
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr // APB error
);
  import crs_pkg::*;

  initial
  begin
    if (NUM_IRQ < 1 || NUM_IRQ > 64)
      $error("NUM_IRQ out of range");
  end

  // ************************************************************
  // State
  // ************************************************************
  crs_state_t state_reg;
  crs_tag_t tag_reg;
  crs_flags_t fl_reg;
  logic [2:0] cnt_reg;
  logic [15:0] hx_reg;
  logic [15:0] sp_reg;
  logic [15:0] pc_reg;
  logic [15:0] vec_reg;
  logic [7:0] acc_reg;
  logic [7:0] imm_reg;
  logic imm_to_sp_reg;
  logic ret_reg;
  logic [1:0] ctrl_reg;
  crs_flags_t fl_next;
  logic [7:0] res_next;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic cin;
  logic taken;
  logic take_cmd;
  logic irq_any;
  logic [5:0] irq_idx;
  logic brk_take;

  assign take_cmd = cmd.valid && state_reg == S_IDLE;
  assign brk_take = ctrl_reg[CRS_CTRL_BRK_EN] && brk_req && !brk_active;

  // RULE21 lowest index wins
  always_comb
  begin
    irq_any = |irq_pend;
    irq_idx = '0;
    for (int k = NUM_IRQ - 1; k >= 0; k--)
      if (irq_pend[k])
        irq_idx = 6'(k);
  end

  // ************************************************************
  // Flag and result logic
  // ************************************************************
  always_comb
  begin
    fl_next = fl_reg;
    res_next = acc_reg;
    cin = (cmd.kind == OP_ADC || cmd.kind == OP_SBC) ? fl_reg.c : 1'b0;
    sum9 = '0;
    half5 = '0;
    unique case (cmd.kind)
      OP_ADD, OP_ADC:
      begin
        sum9 = {1'b0, acc_reg} + {1'b0, cmd.data[7:0]} + {8'h00, cin};
        half5 = {1'b0, acc_reg[3:0]} + {1'b0, cmd.data[3:0]} + {4'h0, cin};
        res_next = sum9[7:0];
        // RULE10 carry out of bit 3
        fl_next.h = half5[4];
        // RULE9 signed overflow on add
        fl_next.v = (acc_reg[7] == cmd.data[7]) && (sum9[7] != acc_reg[7]);
        // RULE18 carry out of bit 7
        fl_next.c = sum9[8];
      end
      OP_SUB, OP_SBC:
      begin
        sum9 = {1'b0, acc_reg} - {1'b0, cmd.data[7:0]} - {8'h00, cin};
        res_next = sum9[7:0];
        fl_next.v = (acc_reg[7] != cmd.data[7]) && (sum9[7] != acc_reg[7]);
        // RULE18 borrow on subtract
        fl_next.c = sum9[8];
      end
      OP_AND, OP_ORA, OP_EOR, OP_LDA:
      begin
        res_next = cmd.kind == OP_AND ? acc_reg & cmd.data[7:0] :
                   cmd.kind == OP_ORA ? acc_reg | cmd.data[7:0] :
                   cmd.kind == OP_EOR ? acc_reg ^ cmd.data[7:0] : cmd.data[7:0];
        fl_next.v = 1'b0;
      end
      OP_ASL, OP_LSR, OP_ASR:
      begin
        res_next = cmd.kind == OP_ASL ? {acc_reg[6:0], 1'b0} :
                   cmd.kind == OP_LSR ? {1'b0, acc_reg[7:1]} : {acc_reg[7], acc_reg[7:1]};
        // RULE18 shifts update carry
        fl_next.c = cmd.kind == OP_ASL ? acc_reg[7] : acc_reg[0];
        fl_next.v = res_next[7] ^ fl_next.c;
      end
      // RULE18 tested bit lands in carry
      OP_BIT_TEST: fl_next.c = cmd.data[cmd.data[10:8]];
      default: res_next = acc_reg;
    endcase
    if (cmd.kind >= OP_ADD && cmd.kind <= OP_ASR)
    begin
      // RULE16 negative is bit 7
      fl_next.n = res_next[7];
      // RULE17 zero result
      fl_next.z = res_next == 8'h00;
    end
    // RULE8 fixed ones
    fl_next.one6 = 1'b1;
    fl_next.one5 = 1'b1;
  end

  // RULE9 signed conditions read overflow
  always_comb
  begin
    unique case (cmd.data[10:8])
      3'h0: taken = !(fl_reg.n ^ fl_reg.v);
      3'h1: taken = fl_reg.n ^ fl_reg.v;
      3'h2: taken = !(fl_reg.z | (fl_reg.n ^ fl_reg.v));
      3'h3: taken = fl_reg.z | (fl_reg.n ^ fl_reg.v);
      3'h4: taken = fl_reg.z;
      3'h5: taken = !fl_reg.z;
      3'h6: taken = fl_reg.c;
      default: taken = !fl_reg.c;
    endcase
  end

  // ************************************************************
  // Register set and sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // RULE2 stack reset value
      sp_reg <= CRS_STACK_RESET;
      // RULE15 mask set by reset
      fl_reg <= CRS_FLAGS_RESET;
      // RULE7 reset vector fetch follows release
      state_reg <= S_VEC;
      vec_reg <= CRS_RESET_VEC;
      busy <= 1'b1;
      hx_reg <= '0;
      pc_reg <= '0;
      acc_reg <= '0;
      cnt_reg <= CRS_CNT_RESET;
      tag_reg <= T_NONE;
      mem <= '0;
      eff_addr <= '0;
      imm_reg <= '0;
      imm_to_sp_reg <= 1'b0;
      ret_reg <= 1'b0;
      irq_ack <= 1'b0;
      irq_ack_idx <= '0;
      brk_active <= 1'b0;
    end
    else
    begin
      mem.rd <= 1'b0;
      mem.wr <= 1'b0;
      irq_ack <= 1'b0;
      tag_reg <= T_NONE;
      if (mem.rd)
      begin
        unique case (tag_reg)
          T_FETCH_HI: pc_reg[15:8] <= mem_rdata;
          T_FETCH_LO: pc_reg[7:0] <= mem_rdata;
          // RULE14 mask restored from stack
          T_FLAGS: fl_reg <= mem_rdata | 8'h60;
          T_ACC: acc_reg <= mem_rdata;
          T_IDX_LO: hx_reg[7:0] <= mem_rdata;
          T_IDX_HI: hx_reg[15:8] <= mem_rdata;
          default: hx_reg <= hx_reg;
        endcase
      end
      unique case (state_reg)
        S_IDLE:
        if (take_cmd)
        begin
          unique case (cmd.kind)
            OP_BOUNDARY:
            // RULE19 break trap at instruction end
            if (brk_take)
            begin
              brk_active <= 1'b1;
              vec_reg <= ctrl_reg[CRS_CTRL_MON] ? CRS_BREAK_VEC_MON : CRS_BREAK_VEC;
              state_reg <= S_STACK;
              cnt_reg <= CRS_CNT_RESET;
              busy <= 1'b1;
            end
            // RULE11 masked requests ignored
            else if (!fl_reg.i && irq_any)
            begin
              irq_ack <= 1'b1;
              irq_ack_idx <= 8'(irq_idx);
              vec_reg <= IRQ_VEC_TOP - {9'h000, irq_idx, 1'b0};
              state_reg <= S_STACK;
              cnt_reg <= CRS_CNT_RESET;
              busy <= 1'b1;
            end
            OP_SOFT_TRAP:
            begin
              vec_reg <= CRS_BREAK_VEC;
              state_reg <= S_STACK;
              cnt_reg <= CRS_CNT_RESET;
              busy <= 1'b1;
            end
            OP_TRAP_RETURN:
            begin
              ret_reg <= 1'b1;
              state_reg <= S_UNSTACK;
              cnt_reg <= CRS_CNT_RESET;
              busy <= 1'b1;
            end
            // RULE6 sequential fetch
            OP_FETCH:
            begin
              mem.rd <= 1'b1;
              mem.addr <= pc_reg;
              pc_reg <= pc_reg + 16'h0001;
            end
            OP_JUMP: pc_reg <= cmd.data;
            // RULE6 taken branch reloads counter
            OP_BRANCH:
            if (taken)
              pc_reg <= pc_reg + {{8{cmd.data[7]}}, cmd.data[7:0]};
            // RULE1 index pair load
            OP_LOAD_INDEX: hx_reg <= cmd.data;
            OP_LOAD_STACK: sp_reg <= cmd.data;
            // RULE3 low byte reinit
            OP_STACK_LOW_REINIT: sp_reg[7:0] <= CRS_STACK_LOW_REINIT;
            // RULE4 push then decrement
            OP_PUSH_BYTE, OP_PUSH_POINTER_HIGH:
            begin
              mem.wr <= 1'b1;
              mem.addr <= sp_reg;
              mem.wdata <= cmd.kind == OP_PUSH_BYTE ? cmd.data[7:0] : hx_reg[15:8];
              sp_reg <= sp_reg - 16'h0001;
            end
            // RULE4 increment then pull
            OP_PULL_ACC, OP_PULL_POINTER_HIGH:
            begin
              mem.rd <= 1'b1;
              mem.addr <= sp_reg + 16'h0001;
              sp_reg <= sp_reg + 16'h0001;
              tag_reg <= cmd.kind == OP_PULL_ACC ? T_ACC : T_IDX_HI;
              state_reg <= S_DONE;
              busy <= 1'b1;
            end
            // RULE15 this op clears mask; trap return also clears it when the stacked mask is clear
            OP_UNMASK: fl_reg.i <= 1'b0;
            OP_MASK: fl_reg.i <= 1'b1;
            OP_IMM_ADD:
            if (cmd.data[15:8] == CRS_OPC_STACK_ADD || cmd.data[15:8] == CRS_OPC_POINTER_ADD)
            begin
              imm_reg <= cmd.data[7:0];
              imm_to_sp_reg <= cmd.data[15:8] == CRS_OPC_STACK_ADD;
              state_reg <= S_IMM;
              busy <= 1'b1;
            end
            // RULE1 indexed operand address
            OP_EA_X8: eff_addr <= hx_reg + {8'h00, cmd.data[7:0]};
            OP_EA_X16: eff_addr <= hx_reg + cmd.data;
            // RULE5 stack-relative operand address
            OP_EA_STK8: eff_addr <= sp_reg + {8'h00, cmd.data[7:0]};
            OP_EA_STK16: eff_addr <= sp_reg + cmd.data;
            // RULE24 only listed flags change
            default:
            begin
              fl_reg <= fl_next;
              if (cmd.kind != OP_BIT_TEST)
                acc_reg <= res_next;
            end
          endcase
        end
        // RULE12 stacking order, index high byte left out
        S_STACK:
        begin
          mem.wr <= 1'b1;
          mem.addr <= sp_reg;
          sp_reg <= sp_reg - 16'h0001;
          // RULE13 index high byte never stacked
          unique case (cnt_reg)
            3'h0: mem.wdata <= pc_reg[7:0];
            3'h1: mem.wdata <= pc_reg[15:8];
            3'h2: mem.wdata <= hx_reg[7:0];
            3'h3: mem.wdata <= acc_reg;
            default: mem.wdata <= fl_reg;
          endcase
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == CRS_FRAME_LAST)
          begin
            // RULE12 mask after stacking, before vector
            fl_reg.i <= 1'b1;
            state_reg <= S_VEC;
            cnt_reg <= CRS_CNT_RESET;
          end
        end
        S_VEC:
        begin
          mem.rd <= 1'b1;
          mem.addr <= cnt_reg == CRS_CNT_RESET ? vec_reg : vec_reg + 16'h0001;
          tag_reg <= cnt_reg == CRS_CNT_RESET ? T_FETCH_HI : T_FETCH_LO;
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg != CRS_CNT_RESET)
            state_reg <= S_DONE;
        end
        // RULE14 pull frame in reverse order
        S_UNSTACK:
        begin
          mem.rd <= 1'b1;
          mem.addr <= sp_reg + 16'h0001;
          sp_reg <= sp_reg + 16'h0001;
          unique case (cnt_reg)
            3'h0: tag_reg <= T_FLAGS;
            3'h1: tag_reg <= T_ACC;
            3'h2: tag_reg <= T_IDX_LO;
            3'h3: tag_reg <= T_FETCH_HI;
            default: tag_reg <= T_FETCH_LO;
          endcase
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == CRS_FRAME_LAST)
            state_reg <= S_DONE;
        end
        // Last read lands here; returns to idle
        S_DONE:
        begin
          // RULE20 break ends on return once request is gone
          if (ret_reg && !brk_req)
            brk_active <= 1'b0;
          ret_reg <= 1'b0;
          state_reg <= S_IDLE;
          busy <= 1'b0;
        end
        // RULE22 second cycle of immediate add, flags untouched
        S_IMM:
        begin
          if (imm_to_sp_reg)
            sp_reg <= sp_reg + {{8{imm_reg[7]}}, imm_reg};
          // RULE23 pointer add immediate
          else
            hx_reg <= hx_reg + {{8{imm_reg[7]}}, imm_reg};
          state_reg <= S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  assign index_pair = hx_reg;
  assign stack_top_pointer = sp_reg;
  assign fetch_address_counter = pc_reg;
  assign result_flag_register = fl_reg;
  assign acc = acc_reg;

  // ************************************************************
  // APB debug window
  // ************************************************************
  // RULE25 window is a side port, not the core's memory map
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      ctrl_reg <= CRS_CTRL_RESET;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && penable && !pready)
      begin
        unique case (paddr)
          CRS_OFS_INDEX: prdata <= {16'h0000, hx_reg};
          CRS_OFS_STACK: prdata <= {16'h0000, sp_reg};
          CRS_OFS_FETCH: prdata <= {16'h0000, pc_reg};
          CRS_OFS_FLAGS: prdata <= {16'h0000, acc_reg, fl_reg};
          CRS_OFS_CTRL: prdata <= {30'h00000000, ctrl_reg};
          CRS_OFS_STAT: prdata <= {24'h000000, 3'h0, state_reg, brk_active, busy};
          default: pslverr <= 1'b1;
        endcase
      end
      // Write lands only at the edge that completes the transfer
      if (psel && penable && pready && pwrite && paddr == CRS_OFS_CTRL)
        ctrl_reg <= pwdata[1:0];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_fixed_ones: assert property (result_flag_register.one6 && result_flag_register.one5) // RULE8
    else $error("flag bits 6 and 5 not one");
  a_low_reinit: assert property (take_cmd && cmd.kind == OP_STACK_LOW_REINIT |=>
      sp_reg[7:0] == 8'hff && sp_reg[15:8] == $past(sp_reg[15:8])) // RULE3
    else $error("stack low reinit wrong");
  a_push_dec: assert property (take_cmd && cmd.kind == OP_PUSH_BYTE |=>
      sp_reg == $past(sp_reg) - 16'h0001 && mem.wr && mem.addr == $past(sp_reg)) // RULE4
    else $error("push did not decrement");
  a_fetch_inc: assert property (take_cmd && cmd.kind == OP_FETCH |=>
      pc_reg == $past(pc_reg) + 16'h0001) // RULE6
    else $error("fetch did not increment");
  a_stack_add: assert property (take_cmd && cmd.kind == OP_IMM_ADD &&
      cmd.data[15:8] == 8'ha7 |=> busy ##1 !busy &&
      sp_reg == $past(sp_reg, 2) + {{8{$past(cmd.data[7], 2)}}, $past(cmd.data[7:0], 2)} &&
      fl_reg == $past(fl_reg, 2)) // RULE22
    else $error("stack add immediate wrong");
  a_mask_blocks: assert property (take_cmd && cmd.kind == OP_BOUNDARY && fl_reg.i &&
      !brk_take |=> state_reg == S_IDLE && !irq_ack) // RULE11
    else $error("masked request taken");
  a_mask_order: assert property (state_reg == S_STACK && cnt_reg == 3'h4 |=>
      fl_reg.i && state_reg == S_VEC ##1 mem.rd && mem.addr == vec_reg) // RULE12
    else $error("mask not set before vector");
  a_zero_flag: assert property (take_cmd && cmd.kind inside {[OP_ADD:OP_ASR]} |=>
      fl_reg.z == (acc_reg == 8'h00) && fl_reg.n == acc_reg[7]) // RULE17
    else $error("zero or negative flag wrong");
  a_no_hi_stack: assert property (state_reg == S_STACK && cnt_reg == 3'h2 |=>
      mem.wdata == $past(hx_reg[7:0])) // RULE13
    else $error("wrong byte stacked");

  c_irq_entry: cover property (irq_ack ##[1:12] state_reg == S_DONE);
  c_break_return: cover property (brk_active ##[1:40] !brk_active);
  c_pointer_add: cover property (take_cmd && cmd.kind == OP_IMM_ADD && cmd.data[15:8] == 8'haf);
endmodule : crs_core_regs

// ### verif/crs_mem_model.sv
// Memory model on the far side of the core register set.
// Assumes reads are answered in the cycle mem.rd is high.
`timescale 1ns/1ps
module crs_mem_model
  import crs_pkg::*;
(
  input wire logic clk, // Core clock
  input wire crs_pkg::crs_mem_t mem, // Request from core
  output logic [7:0] rdata // Read byte
);
  logic [7:0] store [0:65535];
  logic [7:0] last = 8'h00;
  initial
  begin
    store[16'hfffe] = 8'h12;
    store[16'hffff] = 8'h34;
    store[16'hfff8] = 8'h20;
    store[16'hfff9] = 8'h40;
    store[16'hfffc] = 8'h30;
    store[16'hfffd] = 8'h50;
    store[16'hfefc] = 8'h60;
    store[16'hfefd] = 8'h70;
  end
  // Released bus shows the inverse, so a stale byte is never mistaken
  assign rdata = mem.rd ? store[mem.addr] : ~last;
  always @(posedge clk)
  begin
    if (mem.rd)
      last <= store[mem.addr];
    if (mem.wr)
      store[mem.addr] <= mem.wdata;
  end
endmodule : crs_mem_model

// ### verif/testbench.sv
// Self-checking bench for the core register set.
// Assumes the memory model and an APB master task on one clock.
`timescale 1ns/1ps
module testbench;
  import crs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  crs_cmd_t cmd = '0;
  logic [7:0] irq_pend = 8'h00;
  logic brk_req = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  crs_mem_t mem;
  crs_flags_t flags;
  logic busy, irq_ack, brk_active, pready, pslverr, err, got_ack;
  logic [15:0] index_pair, stack, fetch, eff_addr;
  logic [7:0] acc, ack_idx, got_idx, mem_rdata;
  logic [31:0] prdata, rd;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  crs_core_regs dut (.clk(clk), .rst_b(rst_b), .cmd(cmd), .mem_rdata(mem_rdata),
    .irq_pend(irq_pend), .brk_req(brk_req), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .mem(mem), .busy(busy),
    .index_pair(index_pair), .stack_top_pointer(stack), .fetch_address_counter(fetch),
    .result_flag_register(flags), .acc(acc), .eff_addr(eff_addr), .irq_ack(irq_ack),
    .irq_ack_idx(ack_idx), .brk_active(brk_active), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  crs_mem_model mem_model (.clk(clk), .mem(mem), .rdata(mem_rdata));
  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
    if (irq_ack === 1'b1)
    begin
      got_ack <= 1'b1;
      got_idx <= ack_idx;
    end
  end
  // Samples at the falling edge, where registered outputs have settled
  task automatic wait_idle;
    @(negedge clk);
    while (busy !== 1'b0)
      @(negedge clk);
  endtask : wait_idle
  task automatic run_op(input crs_kind_t k, input logic [15:0] d);
    @(posedge clk);
    cmd <= '{valid: 1'b1, kind: k, data: d};
    @(posedge clk);
    cmd <= '0;
    wait_idle();
  endtask : run_op
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset;
    wait_idle();
    chk(stack, 32'h00ff);
    chk(flags, 32'h68);
    chk(fetch, 32'h1234);
    apb(1'b1, CRS_OFS_STACK, 32'h0300);
    apb(1'b0, CRS_OFS_STACK, 32'h0);
    chk(rd, 32'h00ff);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_stack;
    run_op(OP_LOAD_STACK, 16'h0180);
    run_op(OP_STACK_LOW_REINIT, 16'h0);
    chk(stack, 32'h01ff);
    run_op(OP_PUSH_BYTE, 16'h0);
    chk(stack, 32'h01fe);
    run_op(OP_IMM_ADD, 16'ha7fe);
    chk(stack, 32'h01fc);
    run_op(OP_LOAD_INDEX, 16'h12ff);
    run_op(OP_IMM_ADD, 16'haf01);
    chk(index_pair, 32'h1300);
    run_op(OP_EA_STK8, 16'h0010);
    chk(eff_addr, 32'h020c);
  endtask : t_stack
  task automatic t_alu;
    run_op(OP_LDA, 16'h007f);
    run_op(OP_ADD, 16'h0001);
    chk({acc, flags}, 32'h80fc);
    run_op(OP_ADD, 16'h0080);
    chk({acc, flags}, 32'h00eb);
    run_op(OP_IMM_ADD, 16'ha702);
    chk({stack, flags}, 32'h01feeb);
  endtask : t_alu
  task automatic t_irq;
    got_ack = 1'b0;
    @(posedge clk);
    irq_pend <= 8'h0a;
    run_op(OP_BOUNDARY, 16'h0);
    chk(got_ack, 32'h0);
    run_op(OP_UNMASK, 16'h0);
    chk(flags, 32'he3);
    run_op(OP_BOUNDARY, 16'h0);
    chk({got_ack, got_idx}, 32'h101);
    chk({fetch, stack}, 32'h204001f9);
    chk(flags, 32'heb);
    @(posedge clk);
    irq_pend <= 8'h00;
    run_op(OP_TRAP_RETURN, 16'h0);
    chk({fetch, stack}, 32'h123401fe);
    chk(flags, 32'he3);
  endtask : t_irq
  task automatic t_brk;
    apb(1'b1, CRS_OFS_CTRL, 32'h1);
    brk_req <= 1'b1;
    run_op(OP_BOUNDARY, 16'h0);
    chk({brk_active, fetch}, 32'h13050);
    @(posedge clk);
    brk_req <= 1'b0;
    run_op(OP_TRAP_RETURN, 16'h0);
    chk({brk_active, fetch}, 32'h01234);
  endtask : t_brk
  task automatic t_ops;
    run_op(OP_JUMP, 16'h0100);
    run_op(OP_FETCH, 16'h0);
    chk(fetch, 32'h0101);
    run_op(OP_BRANCH, 16'h04f0);
    chk(fetch, 32'h00f1);
    run_op(OP_LDA, 16'h0010);
    run_op(OP_SUB, 16'h0020);
    chk({acc, flags}, 32'hf065);
    run_op(OP_PUSH_POINTER_HIGH, 16'h0);
    run_op(OP_LOAD_INDEX, 16'h0000);
    run_op(OP_PULL_POINTER_HIGH, 16'h0);
    chk(index_pair, 32'h1300);
    run_op(OP_EA_X8, 16'h0021);
    chk(eff_addr, 32'h1321);
    apb(1'b1, CRS_OFS_CTRL, 32'h3);
    brk_req <= 1'b1;
    run_op(OP_BOUNDARY, 16'h0);
    chk({brk_active, fetch}, 32'h16070);
    @(posedge clk);
    brk_req <= 1'b0;
    run_op(OP_TRAP_RETURN, 16'h0);
    chk({brk_active, fetch, flags}, 32'h00f165);
  endtask : t_ops
  initial
  begin
    got_ack = 1'b0;
    got_idx = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_stack();
    t_alu();
    t_irq();
    t_brk();
    t_ops();
    report_and_stop();
  end
endmodule : testbench
